// ---- verilog/tsw_consts.svh ----
// Constants for the transfer switch mode controller: timing counts, codes.
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH
`define TSW_CLK_HZ          40000000
`define TSW_XFER_DELAY_MS   1000
`define TSW_RETURN_DELAY_MS 5000
`define TSW_COOL_DELAY_MS   60000
`define TSW_PAGE_REVERT_MS  300000
`define TSW_AUTOSCROLL_MS   2000
`define TSW_INFO_TOGGLE_MS  2000
`define TSW_MS_CYCLES       (`TSW_CLK_HZ / 1000)
`define TSW_PAGE_STATUS     3'h0
`define TSW_PAGE_ALARMS     3'h5
`define TSW_PAGE_LAST       3'h7
`define TSW_ALARM_W         8
`define TSW_INSTR_LAST      4'hf
`endif

// ---- verilog/tsw_pkg.sv ----
// Types shared by the transfer switch mode controller.
package tsw_pkg;
  // Front-panel buttons, each a level from the panel.
  typedef struct packed {
    logic stopReset;
    logic manual;
    logic auto;
    logic mode;
    logic accept;
    logic muteLamp;
    logic xferInfo;
    logic closePrimary;
    logic closeBackup;
    logic nextPage;
    logic scrollUp;
    logic scrollDown;
  } tsw_buttons_t;
  // Plant status inputs.
  typedef struct packed {
    logic remoteStart;
    logic primaryHealthy;
    logic backupHealthy;
    logic backupIsGen;
    logic returnCmd;
  } tsw_plant_t;
  // Top-level operating mode.
  typedef enum logic [2:0] {
    TSW_MODE_STOP   = 3'b001,
    TSW_MODE_MANUAL = 3'b010,
    TSW_MODE_AUTO   = 3'b100
  } tsw_mode_t;
  // Extra modes selected by the mode button.
  typedef enum logic [3:0] {
    TSW_XM_NONE     = 4'b0001,
    TSW_XM_TEST_ON  = 4'b0010,
    TSW_XM_TEST_OFF = 4'b0100,
    TSW_XM_NO_RET   = 4'b1000
  } tsw_xmode_t;
  // Transfer sequencer states.
  typedef enum logic [4:0] {
    TSW_SQ_IDLE    = 5'b00001,
    TSW_SQ_TO_PRI  = 5'b00010,
    TSW_SQ_TO_BAK  = 5'b00100,
    TSW_SQ_RETWAIT = 5'b01000,
    TSW_SQ_COOL    = 5'b10000
  } tsw_seq_t;
  // Display outputs.
  typedef struct packed {
    logic [2:0] page;
    logic [3:0] instrument;
    logic       infoShown;
    logic       infoBackup;
  } tsw_display_t;
endpackage

// ---- verilog/tsw_delay_timer.sv ----
// Restartable down-counter that pulses done once a delay has elapsed.
`timescale 1ns/1ps
module tsw_delay_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             cancel,
  input  wire logic [WIDTH-1:0] cycles,
  output logic                  done,
  output logic                  running
);
  if (WIDTH < 2) begin : g_bad_width
    $error("tsw_delay_timer: WIDTH too small");
  end

  logic [WIDTH-1:0] count;  // Cycles still to wait.

  // Start reloads, cancel stops silently, terminal count gives one pulse.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count   <= (cycles == '0) ? '0 : cycles - 1'b1;
      running <= 1'b1;
      done    <= 1'b0;
    end else if (cancel) begin
      running <= 1'b0;
      done    <= 1'b0;
    end else if (running && count == '0) begin
      running <= 1'b0;
      done    <= 1'b1;
    end else begin
      count <= running ? count - 1'b1 : count;
      done  <= 1'b0;
    end
  end
endmodule

// ---- verilog/tsw_mode_control.sv ----
// Mode, transfer and display control for a two-source transfer switch.
// What this block does
// - Stop clears alarms whose cause is gone.
// - Stop drops backup close output.
// - Stop removes generator start request.
// - Remote start ignored in stop mode.
// - Manual starts generator, keeps backup unloaded.
// - Auto: remote start starts, loads backup.
// - Auto return: return delay, cooling, then stop.
// - Mode button cycles; accept button applies.
// - Test-on-load starts and loads backup.
// - Test-off-load starts backup, switch stays open.
// - Prohibit-return holds backup until return command.
// - Mute silences horn and lights lamps.
// - Info button shows alternating transfer records.
// - Close/open buttons work only in manual.
// - Primary button opens primary when loaded.
// - Primary button: open backup, delay, close.
// - Backup button opens backup when loaded.
// - Backup button: open primary, delay, close.
// - Page persists; idle timeout returns to status.
// - Idle instrument page autoscrolls at interval.
// - Manual scroll stops autoscroll; title re-enables.
// - New alarm on status page shows alarms.
`timescale 1ns/1ps
`include "tsw_consts.svh"
module tsw_mode_control #(
  parameter int unsigned ALARM_W       = `TSW_ALARM_W,
  parameter int unsigned XFER_MS       = `TSW_XFER_DELAY_MS,
  parameter int unsigned RETURN_MS     = `TSW_RETURN_DELAY_MS,
  parameter int unsigned COOL_MS       = `TSW_COOL_DELAY_MS,
  parameter int unsigned PAGE_MS       = `TSW_PAGE_REVERT_MS,
  parameter int unsigned SCROLL_MS     = `TSW_AUTOSCROLL_MS,
  parameter int unsigned INFO_MS       = `TSW_INFO_TOGGLE_MS,
  parameter int unsigned CYCLES_PER_MS = `TSW_MS_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire tsw_pkg::tsw_buttons_t buttons,
  input  wire tsw_pkg::tsw_plant_t  plant,
  input  wire logic [ALARM_W-1:0]   alarmCond,
  output tsw_pkg::tsw_mode_t        mode,
  output tsw_pkg::tsw_xmode_t       extraMode,
  output tsw_pkg::tsw_xmode_t       pendingMode,
  output logic                      primaryClose,
  output logic                      backupClose,
  output logic                      genStart,
  output logic [ALARM_W-1:0]        alarmLatched,
  output logic                      horn,
  output logic                      lampTest,
  output tsw_pkg::tsw_display_t     display
);
  import tsw_pkg::*;

  if (ALARM_W < 1 || CYCLES_PER_MS < 1) begin : g_bad_param
    $error("tsw_mode_control: bad parameter");
  end
  if (64'(COOL_MS) * 64'(CYCLES_PER_MS) >= 64'h1_0000_0000) begin : g_ovf
    $error("tsw_mode_control: cool timer overflows");
  end

  // Cycle counts derived from the times; a zero time gives a zero count.
  localparam logic [31:0] XFER_CYC   = 32'(XFER_MS * CYCLES_PER_MS);
  localparam logic [31:0] RETURN_CYC = 32'(RETURN_MS * CYCLES_PER_MS);
  localparam logic [31:0] COOL_CYC   = 32'(COOL_MS * CYCLES_PER_MS);
  localparam logic [63:0] PAGE_CYC   = 64'(PAGE_MS) * 64'(CYCLES_PER_MS);
  localparam logic [31:0] SCROLL_CYC = 32'(SCROLL_MS * CYCLES_PER_MS);
  localparam logic [31:0] INFO_CYC   = 32'(INFO_MS * CYCLES_PER_MS);

  // Two-flop synchronisers for every pin input; alarm causes included.
  localparam int unsigned NSYNC = $bits(tsw_buttons_t) + $bits(tsw_plant_t)
                                  + ALARM_W;
  logic [NSYNC-1:0] syncMeta;  // First stage, read only by the second.
  logic [NSYNC-1:0] syncQ;     // Second stage, safe to use.
  logic [NSYNC-1:0] syncPrev;  // Delayed copy for edge detection.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncMeta <= '0;
      syncQ    <= '0;
      syncPrev <= '0;
    end else begin
      syncMeta <= {buttons, plant, alarmCond};
      syncQ    <= syncMeta;
      syncPrev <= syncQ;
    end
  end

  tsw_buttons_t        btn;       // Synchronised button levels.
  tsw_buttons_t        press;     // One-cycle press pulses.
  tsw_plant_t          pl;        // Synchronised plant status.
  logic [ALARM_W-1:0]  cond;      // Synchronised alarm causes.
  logic [ALARM_W-1:0]  condPrev;  // Previous alarm causes.
  assign {btn, pl, cond} = syncQ;
  assign press = tsw_buttons_t'(syncQ[NSYNC-1 -: $bits(tsw_buttons_t)]
                 & ~syncPrev[NSYNC-1 -: $bits(tsw_buttons_t)]);
  assign condPrev = syncPrev[ALARM_W-1:0];
  logic anyPress;  // Any button went down this cycle.
  assign anyPress = |press;

  // Operating mode follows the three mode buttons; stop takes priority.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= TSW_MODE_STOP;
    end else if (press.stopReset) begin
      mode <= TSW_MODE_STOP;
    end else if (press.manual) begin
      mode <= TSW_MODE_MANUAL;
    end else if (press.auto) begin
      mode <= TSW_MODE_AUTO;
    end
  end

  // Mode button steps the pending choice, accept applies it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pendingMode <= TSW_XM_NONE;
      extraMode   <= TSW_XM_NONE;
    end else begin
      if (press.mode) begin
        unique case (pendingMode)
          TSW_XM_NONE:     pendingMode <= TSW_XM_TEST_ON;
          TSW_XM_TEST_ON:  pendingMode <= TSW_XM_TEST_OFF;
          TSW_XM_TEST_OFF: pendingMode <= TSW_XM_NO_RET;
          default:         pendingMode <= TSW_XM_NONE;
        endcase
      end
      if (press.accept) begin
        extraMode <= pendingMode;
      end
    end
  end

  // Whether the automatic logic wants the backup source running and loaded.
  logic inStop;      // Stop mode is active.
  logic autoDemand;  // Start request seen in auto mode.
  logic wantRun;     // Backup should run.
  logic wantLoad;    // Backup should carry the load.
  assign inStop     = (mode == TSW_MODE_STOP);
  assign autoDemand = (mode == TSW_MODE_AUTO)
                      && (pl.remoteStart || !pl.primaryHealthy);
  assign wantLoad   = !inStop && (autoDemand
                      || extraMode == TSW_XM_TEST_ON);
  assign wantRun    = wantLoad || (mode == TSW_MODE_MANUAL)
                      || (!inStop && extraMode == TSW_XM_TEST_OFF);

  // Shared delay timer serves transfer, return and cooling waits.
  tsw_seq_t    seq;       // Transfer sequencer state.
  logic        tmrStart;  // Load the timer.
  logic [31:0] tmrCyc;    // Delay to load.
  logic        tmrDone;   // Delay elapsed pulse.
  tsw_delay_timer #(.WIDTH(32)) uSeqTimer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (tmrStart),
    .cancel   (inStop),
    .cycles   (tmrCyc),
    .done     (tmrDone),
    .running  ()
  );

  // Requests to begin a make-after-break transfer.
  logic goPrimary;  // Move load onto primary.
  logic goBackup;   // Move load onto backup.
  logic manual;     // Manual mode active.
  assign manual    = (mode == TSW_MODE_MANUAL);
  assign goPrimary = manual && press.closePrimary && backupClose
                     && pl.primaryHealthy;
  assign goBackup  = (seq == TSW_SQ_IDLE) && !backupClose && pl.backupHealthy
                     && ((manual && press.closeBackup && primaryClose)
                     || (!manual && wantLoad && genStart));
  logic returnOk;   // Automatic return to primary may begin.
  assign returnOk  = !manual && backupClose && !wantLoad && pl.primaryHealthy
                     && (extraMode != TSW_XM_NO_RET || pl.returnCmd);

  // Sequencer: break first, wait, then make; never both closed.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq <= TSW_SQ_IDLE;
    end else if (inStop) begin
      seq <= TSW_SQ_IDLE;
    end else begin
      unique case (seq)
        TSW_SQ_IDLE: begin
          if (goPrimary) seq <= TSW_SQ_TO_PRI;
          else if (goBackup) seq <= TSW_SQ_TO_BAK;
          else if (returnOk) seq <= TSW_SQ_RETWAIT;
        end
        TSW_SQ_TO_PRI: if (tmrDone) seq <= (mode == TSW_MODE_AUTO
                       && !genStart) ? TSW_SQ_IDLE
                       : (manual ? TSW_SQ_IDLE : TSW_SQ_COOL);
        TSW_SQ_TO_BAK: if (tmrDone) seq <= TSW_SQ_IDLE;
        TSW_SQ_RETWAIT: begin
          if (!returnOk) seq <= TSW_SQ_IDLE;
          else if (tmrDone) seq <= TSW_SQ_TO_PRI;
        end
        TSW_SQ_COOL: if (tmrDone || wantLoad) seq <= TSW_SQ_IDLE;
        default: seq <= TSW_SQ_IDLE;
      endcase
    end
  end

  // Timer loads on every state entry that waits.
  always_comb begin
    tmrStart = 1'b0;
    tmrCyc   = XFER_CYC;
    if (!inStop && seq == TSW_SQ_IDLE && (goPrimary || goBackup)) begin
      tmrStart = 1'b1;
    end else if (!inStop && seq == TSW_SQ_IDLE && returnOk) begin
      tmrStart = 1'b1;
      tmrCyc   = RETURN_CYC;
    end else if (seq == TSW_SQ_RETWAIT && returnOk && tmrDone) begin
      tmrStart = 1'b1;
    end else if (seq == TSW_SQ_TO_PRI && tmrDone && !manual) begin
      tmrStart = 1'b1;
      tmrCyc   = COOL_CYC;
    end
  end

  // Load switch outputs; each close waits for the other to be open.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primaryClose <= 1'b0;
      backupClose  <= 1'b0;
    end else if (inStop) begin
      backupClose <= 1'b0;
    end else if (seq == TSW_SQ_IDLE && goPrimary) begin
      backupClose <= 1'b0;
    end else if (seq == TSW_SQ_IDLE && goBackup) begin
      primaryClose <= 1'b0;
    end else if (seq == TSW_SQ_RETWAIT && returnOk && tmrDone) begin
      backupClose <= 1'b0;
    end else if (seq == TSW_SQ_TO_PRI && tmrDone && !backupClose) begin
      primaryClose <= 1'b1;
    end else if (seq == TSW_SQ_TO_BAK && tmrDone && !primaryClose) begin
      backupClose <= 1'b1;
    end else if (seq == TSW_SQ_IDLE && manual && press.closePrimary
                 && primaryClose) begin
      primaryClose <= 1'b0;
    end else if (seq == TSW_SQ_IDLE && manual && press.closeBackup
                 && backupClose) begin
      backupClose <= 1'b0;
    end
  end

  // Generator start request; held through return and cooling.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      genStart <= 1'b0;
    end else if (inStop || !pl.backupIsGen) begin
      genStart <= 1'b0;
    end else if (wantRun) begin
      genStart <= 1'b1;
    end else if (seq == TSW_SQ_IDLE && !backupClose) begin
      genStart <= 1'b0;
    end
  end

  // Alarms latch on their cause; stop clears those whose cause is gone.
  logic alarmNew;  // Some alarm rose this cycle.
  assign alarmNew = |(cond & ~condPrev);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarmLatched <= '0;
    end else if (press.stopReset) begin
      alarmLatched <= alarmLatched & cond;
    end else begin
      alarmLatched <= alarmLatched | cond;
    end
  end

  // Horn sounds on a new alarm until muted; a new alarm wins over mute.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      horn     <= 1'b0;
      lampTest <= 1'b0;
    end else begin
      horn     <= alarmNew || (horn && !press.muteLamp);
      lampTest <= btn.muteLamp;
    end
  end

  // Display idle timers: page revert, autoscroll step and info toggle.
  logic [63:0] idleCnt;    // Cycles since last press; wide for long reverts.
  logic [31:0] scrollCnt;  // Cycles toward next autoscroll step.
  logic [31:0] infoCnt;    // Cycles toward the next record swap.
  logic        autoOn;     // Autoscroll enabled.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idleCnt   <= '0;
      scrollCnt <= '0;
    end else begin
      idleCnt   <= anyPress ? '0 : (idleCnt == PAGE_CYC ? idleCnt
                   : idleCnt + 64'h1);
      scrollCnt <= (anyPress || scrollCnt == SCROLL_CYC - 32'h1) ? '0
                   : scrollCnt + 32'h1;
    end
  end

  // Page and instrument selection with autoscroll and alarm takeover.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      display.page       <= `TSW_PAGE_STATUS;
      display.instrument <= '0;
      autoOn             <= 1'b1;
    end else if (press.nextPage) begin
      display.page       <= display.page == `TSW_PAGE_LAST
                            ? `TSW_PAGE_STATUS : display.page + 3'h1;
      display.instrument <= '0;
      autoOn             <= 1'b1;
    end else if (press.scrollDown || press.scrollUp) begin
      display.instrument <= press.scrollDown ? display.instrument + 4'h1
                            : display.instrument - 4'h1;
      autoOn <= press.scrollUp && display.instrument == 4'h1;
    end else if (idleCnt == PAGE_CYC - 64'h1) begin
      display.page       <= `TSW_PAGE_STATUS;
      display.instrument <= '0;
      autoOn             <= 1'b1;
    end else if (alarmNew && display.page == `TSW_PAGE_STATUS) begin
      display.page       <= `TSW_PAGE_ALARMS;
      display.instrument <= '0;
    end else if (autoOn && scrollCnt == SCROLL_CYC - 32'h1) begin
      display.instrument <= display.instrument == `TSW_INSTR_LAST
                            ? 4'h0 : display.instrument + 4'h1;
    end
  end

  // Latest transfer records alternate while the info button is held.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      display.infoShown  <= 1'b0;
      display.infoBackup <= 1'b0;
      infoCnt            <= '0;
    end else if (!btn.xferInfo) begin
      display.infoShown  <= 1'b0;
      display.infoBackup <= 1'b0;
      infoCnt            <= '0;
    end else begin
      display.infoShown <= 1'b1;
      if (infoCnt == INFO_CYC - 32'h1) begin
        infoCnt            <= '0;
        display.infoBackup <= !display.infoBackup;
      end else begin
        infoCnt <= infoCnt + 32'h1;
      end
    end
  end
endmodule

// ---- tb/tsw_mode_control_chk.sv ----
// Port checker of the transfer switch mode controller, with its bind.
`timescale 1ns/1ps
`include "tsw_consts.svh"
module tsw_mode_control_chk #(
  parameter int unsigned ALARM_W       = `TSW_ALARM_W,
  parameter int unsigned XFER_MS       = `TSW_XFER_DELAY_MS,
  parameter int unsigned CYCLES_PER_MS = `TSW_MS_CYCLES
) (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire tsw_pkg::tsw_buttons_t buttons,
  input wire tsw_pkg::tsw_plant_t   plant,
  input wire logic [ALARM_W-1:0]    alarmLatched,
  input wire tsw_pkg::tsw_mode_t    mode,
  input wire tsw_pkg::tsw_xmode_t   extraMode,
  input wire logic                  primaryClose,
  input wire logic                  backupClose,
  input wire logic                  genStart,
  input wire logic                  lampTest,
  input wire tsw_pkg::tsw_display_t display
);
  import tsw_pkg::*;
  localparam int unsigned XC = XFER_MS * CYCLES_PER_MS;  // Transfer gap.
  logic [31:0] priOpen;  // Cycles the primary switch has stood open.
  logic [31:0] bakOpen;  // Cycles the backup switch has stood open.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Reset saturates the count, so a first close after reset is legal.
  always_ff @(posedge core_clk) begin
    if (!rst_n) priOpen <= 32'hffff_ffff;
    else if (primaryClose) priOpen <= 32'h0;
    else if (priOpen != 32'hffff_ffff) priOpen <= priOpen + 32'h1;
  end
  // Same count for the backup switch.
  always_ff @(posedge core_clk) begin
    if (!rst_n) bakOpen <= 32'hffff_ffff;
    else if (backupClose) bakOpen <= 32'h0;
    else if (bakOpen != 32'hffff_ffff) bakOpen <= bakOpen + 32'h1;
  end
  sequence s_backup_made; $rose(backupClose); endsequence
  sequence s_primary_made; $rose(primaryClose); endsequence
  property p_no_overlap; !(primaryClose && backupClose); endproperty
  property p_break_bak; s_backup_made |-> priOpen >= XC; endproperty
  property p_break_pri; s_primary_made |-> bakOpen >= XC; endproperty
  property p_stop_quiet;
    mode == TSW_MODE_STOP && $past(mode) == TSW_MODE_STOP &&
      extraMode == TSW_XM_NONE |-> !genStart && !backupClose;
  endproperty
  property p_lamp; buttons.muteLamp [*4] |-> ##1 lampTest; endproperty
  property p_manual_start;
    $rose(mode == TSW_MODE_MANUAL) && plant.backupIsGen |-> ##[0:2] genStart;
  endproperty
  property p_auto_start;
    (mode == TSW_MODE_AUTO && plant.remoteStart) [*4] |-> ##[0:2] genStart;
  endproperty
  property p_alarm_page;
    display.page == `TSW_PAGE_STATUS &&
      (alarmLatched & ~$past(alarmLatched)) != '0
      |-> ##[0:2] display.page == `TSW_PAGE_ALARMS;
  endproperty
  property p_info; buttons.xferInfo [*4] |-> ##1 display.infoShown; endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both close outputs high");
  a_break_bak: assert property (p_break_bak)
    else $error("backup closed too soon");
  a_break_pri: assert property (p_break_pri)
    else $error("primary closed too soon");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("backup active in stop");
  a_lamp: assert property (p_lamp)
    else $error("lamp test missing");
  a_manual_start: assert property (p_manual_start)
    else $error("no start in manual");
  a_auto_start: assert property (p_auto_start)
    else $error("no start on demand");
  a_alarm_page: assert property (p_alarm_page)
    else $error("alarm page not shown");
  a_info: assert property (p_info)
    else $error("transfer record not shown");
endmodule
bind tsw_mode_control tsw_mode_control_chk #(
  .ALARM_W(ALARM_W), .XFER_MS(XFER_MS), .CYCLES_PER_MS(CYCLES_PER_MS)
) i_tsw_mode_control_chk (
  .core_clk(core_clk), .rst_n(rst_n), .buttons(buttons), .plant(plant),
  .alarmLatched(alarmLatched), .mode(mode), .extraMode(extraMode),
  .primaryClose(primaryClose), .backupClose(backupClose),
  .genStart(genStart), .lampTest(lampTest), .display(display)
);

// ---- tb/tsw_source_model.sv ----
// Backup generator model: reports itself available after a run-up.
`timescale 1ns/1ps
module tsw_source_model #(
  parameter int unsigned RUN_UP = 3
) (
  input  wire logic core_clk,
  input  wire logic genStart,
  output logic      backupOk
);
  logic [7:0] runCnt;  // Cycles run since the start request.
  initial begin
    runCnt = 8'h00;
    backupOk = 1'b0;
  end
  // A dropped request stops the set at once, so health falls with it.
  always @(negedge core_clk) begin
    if (!genStart) runCnt <= 8'h00;
    else if (runCnt != 8'hff) runCnt <= runCnt + 8'h01;
    backupOk <= genStart && (runCnt >= 8'(RUN_UP));
  end
endmodule

// ---- tb/tsw_mode_control_bench.sv ----
// Self-checking bench of the transfer switch mode controller.
`timescale 1ns/1ps
`include "tsw_consts.svh"
module tsw_mode_control_bench;
  import tsw_pkg::*;
  localparam int RC = 6;    // Return delay in cycles.
  localparam int CC = 8;    // Cooling delay in cycles.
  localparam int PC = 200;  // Page revert time in cycles.
  localparam int SC = 20;   // Autoscroll interval in cycles.
  localparam int IC = 10;   // Transfer record toggle in cycles.
  // Bit positions of the buttons in the packed button word.
  localparam int B_STOP = 11, B_MAN = 10, B_AUTO = 9, B_MODE = 8;
  localparam int B_ACC = 7, B_MUTE = 6, B_INFO = 5, B_CPRI = 4;
  localparam int B_CBAK = 3, B_NEXT = 2, B_UP = 1, B_DOWN = 0;
  logic         core_clk, rst_n;
  logic [11:0]  btn;                  // Button levels, high pressed.
  logic         remStart, priOk, bakOk, isGen, retCmd;
  logic [7:0]   alarmCond, alarmLatched;
  tsw_mode_t    mode;
  tsw_xmode_t   extraMode, pendingMode;
  logic         primaryClose, backupClose, genStart, horn, lampTest;
  tsw_display_t display;
  int           n_mismatch, n_checks, cycles;
  tsw_mode_control #(.XFER_MS(4), .RETURN_MS(RC), .COOL_MS(CC),
    .PAGE_MS(PC), .SCROLL_MS(SC), .INFO_MS(IC), .CYCLES_PER_MS(1)
  ) i_tsw_mode_control (
    .core_clk(core_clk), .rst_n(rst_n), .buttons(tsw_buttons_t'(btn)),
    .plant(tsw_plant_t'({remStart, priOk, bakOk, isGen, retCmd})),
    .alarmCond(alarmCond), .mode(mode), .extraMode(extraMode),
    .pendingMode(pendingMode), .primaryClose(primaryClose),
    .backupClose(backupClose), .genStart(genStart),
    .alarmLatched(alarmLatched), .horn(horn), .lampTest(lampTest),
    .display(display));
  tsw_source_model i_tsw_source_model (
    .core_clk(core_clk), .genStart(genStart), .backupOk(bakOk));
  always #12.5 core_clk = ~core_clk;
  // Cuts a hang short; the run needs well under this many cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // A press is held past the synchroniser, then a low gap follows.
  task automatic press(input int b);
    btn[b] = 1'b1;
    tick(4);
    btn[b] = 1'b0;
    tick(8);
  endtask
  task automatic t_display();
    logic b0;
    logic [3:0] i0;
    int k;
    btn[B_INFO] = 1'b1;
    tick(5);
    chk("info", 8'h01, 8'(display.infoShown));
    b0 = display.infoBackup;
    for (k = 0; k < 3 * IC && display.infoBackup === b0; k++) tick(1);
    chk("flip", 8'h01, 8'(display.infoBackup !== b0));
    btn[B_INFO] = 1'b0;
    press(B_NEXT);
    chk("page", 8'h01, 8'(display.page != `TSW_PAGE_STATUS));
    i0 = display.instrument;
    for (k = 0; k < 2 * SC && display.instrument === i0; k++) tick(1);
    chk("scroll", 8'h01, 8'(display.instrument !== i0));
    press(B_DOWN);
    i0 = display.instrument;
    tick(2 * SC);
    chk("held", 8'(i0), 8'(display.instrument));
    for (k = 0; k < 16 && display.instrument != 4'h0; k++) press(B_UP);
    i0 = display.instrument;
    for (k = 0; k < 2 * SC && display.instrument === i0; k++) tick(1);
    chk("rearm", 8'h01, 8'(display.instrument !== i0));
    for (k = 0; k < PC && display.page != `TSW_PAGE_STATUS; k++) tick(1);
    chk("revert", 8'h01, 8'(k >= PC - 3 * SC - 12));
    chk("status", 8'(`TSW_PAGE_STATUS), 8'(display.page));
    alarmCond = 8'h80;
    tick(8);
    chk("alpage", 8'(`TSW_PAGE_ALARMS), 8'(display.page));
    alarmCond = 8'h00;
  endtask
  task automatic t_auto();
    int k;
    press(B_AUTO);
    chk("mode", 8'(TSW_MODE_AUTO), 8'(mode));
    remStart = 1'b1;
    for (k = 0; k < 60 && !backupClose; k++) tick(1);
    chk("agen", 8'h01, 8'(genStart));
    chk("abak", 8'h01, 8'(backupClose));
    remStart = 1'b0;
    for (k = 0; k < 60 && backupClose; k++) tick(1);
    chk("ret", 8'h01, 8'(k >= RC));
    for (k = 0; k < 60 && !primaryClose; k++) tick(1);
    chk("apri", 8'h01, 8'(primaryClose));
    for (k = 0; k < 60 && genStart; k++) tick(1);
    chk("cool", 8'h01, 8'(k >= CC - 2 && !genStart));
    press(B_CBAK);
    tick(10);
    chk("ign", 8'h02, 8'({primaryClose, backupClose}));
  endtask
  task automatic t_manual();
    int k;
    press(B_MAN);
    chk("mgen", 8'h01, 8'(genStart));
    chk("mbak", 8'h00, 8'(backupClose));
    press(B_CBAK);
    tick(4);
    chk("tobak", 8'h01, 8'({primaryClose, backupClose}));
    press(B_CPRI);
    tick(4);
    chk("topri", 8'h02, 8'({primaryClose, backupClose}));
    press(B_CPRI);
    chk("popen", 8'h00, 8'({primaryClose, backupClose}));
    press(B_AUTO);
    remStart = 1'b1;
    for (k = 0; k < 60 && !backupClose; k++) tick(1);
    press(B_MAN);
    remStart = 1'b0;
    press(B_CBAK);
    chk("bopen", 8'h00, 8'({primaryClose, backupClose}));
  endtask
  task automatic t_stop();
    int k;
    press(B_AUTO);
    remStart = 1'b1;
    for (k = 0; k < 60 && !backupClose; k++) tick(1);
    alarmCond = 8'h03;
    tick(6);
    alarmCond = 8'h02;
    tick(6);
    chk("latch", 8'h83, alarmLatched);
    press(B_STOP);
    chk("clear", 8'h02, alarmLatched);
    chk("sbak", 8'h00, 8'(backupClose));
    chk("sgen", 8'h00, 8'(genStart));
    tick(20);
    chk("rem", 8'h00, 8'({genStart, backupClose}));
    chk("horn", 8'h01, 8'(horn));
    btn[B_MUTE] = 1'b1;
    tick(5);
    chk("lamp", 8'h01, 8'(lampTest));
    chk("mute", 8'h00, 8'(horn));
    btn[B_MUTE] = 1'b0;
    remStart = 1'b0;
    alarmCond = 8'h00;
    tick(4);
  endtask
  task automatic t_modes();
    int k;
    press(B_AUTO);
    press(B_MODE);
    chk("pend", 8'(TSW_XM_TEST_ON), 8'(pendingMode));
    chk("keep", 8'(TSW_XM_NONE), 8'(extraMode));
    press(B_ACC);
    chk("xon", 8'(TSW_XM_TEST_ON), 8'(extraMode));
    for (k = 0; k < 60 && !backupClose; k++) tick(1);
    chk("ton", 8'h03, 8'({genStart, backupClose}));
    press(B_MODE);
    press(B_ACC);
    tick(40);
    chk("toff", 8'h02, 8'({genStart, backupClose}));
    press(B_MODE);
    press(B_ACC);
    chk("xret", 8'(TSW_XM_NO_RET), 8'(extraMode));
    remStart = 1'b1;
    for (k = 0; k < 60 && !backupClose; k++) tick(1);
    remStart = 1'b0;
    tick(40);
    chk("hold", 8'h01, 8'(backupClose));
    retCmd = 1'b1;
    for (k = 0; k < 60 && backupClose; k++) tick(1);
    chk("back", 8'h00, 8'(backupClose));
    retCmd = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset is held five cycles, then the syncs get time to settle.
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    btn = 12'h000;
    {remStart, retCmd} = 2'b00;
    {priOk, isGen} = 2'b11;
    alarmCond = 8'h00;
    tick(5);
    rst_n = 1'b1;
    tick(4);
    t_display();
    t_auto();
    t_manual();
    t_stop();
    t_modes();
    test_done();
  end
endmodule
